// ### shared/msp_map.svh
// constants of the management serial packet output
// Operation
// - drive management receive clock only while a port receives; otherwise inactive.
// - change management receive data on the falling edge of that clock.
// - send received data as NRZ while receiving; data line inactive otherwise.
// - stream is the received packet followed by a status field about it.
// - drive carrier sense as framing enable while receiving; otherwise the pin is input.
// - drive enable high whenever the external transceiver should transmit the bus lines.
// - compress the current packet when compress input is low during carrier sense.
// - compress input tied low compresses every packet; tied high inhibits compression.
// - present received data in Manchester format on a dedicated test output.
// - while reset/mode-load is low, all state and outputs are reset and held inactive.
`ifndef MSP_MAP_SVH
`define MSP_MAP_SVH

// =====================================================================
// timing
`define MSP_SYS_CLK_MHZ   125
`define MSP_BIT_TIME_NS   100
// half a status bit, longest time so rounded down, never below one cycle
`define MSP_HALF_BIT_CYC  (((`MSP_BIT_TIME_NS * `MSP_SYS_CLK_MHZ) / 2000) < 1 ? 1 : \
                           ((`MSP_BIT_TIME_NS * `MSP_SYS_CLK_MHZ) / 2000))

// =====================================================================
// frame layout
`define MSP_STATUS_BITS   8
`define MSP_COMP_BITS     512

`endif

// ### shared/msp_pkg.sv
// types of the management serial packet output
package msp_pkg;

  // =====================================================================
  // frame sequencer states
  typedef enum logic [1:0] {
    msp_idle,
    msp_pkt,
    msp_skip,
    msp_stat
  } msp_state_t;

endpackage : msp_pkg

// ### design/msp_manchester_mon.sv
// manchester re-encoder for the receive test monitor
`timescale 1ns/10ps
`default_nettype none

module msp_manchester_mon (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // synchronised decoded stream
  input  wire logic rx_active,
  input  wire logic nrz_clk,
  input  wire logic nrz_data,
  // test output
  output logic      rx_manchester_monitor
);

  // clock low marks the first half of a bit cell, so data xor clock gives
  // the true value then the complement, the usual manchester sense
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_manchester_monitor <= 1'b0;
    end else if (ce) begin
      rx_manchester_monitor <= rx_active & (nrz_data ^ nrz_clk);
    end
  end

endmodule : msp_manchester_mon

`default_nettype wire

// ### design/msp_packet_output.sv
// management bus serial packet output with status trailer and compression
`timescale 1ns/10ps
`default_nettype none
`include "msp_map.svh"

module msp_packet_output
  import msp_pkg::*;
#(
  parameter int STATUS_BITS  = `MSP_STATUS_BITS,
  parameter int COMP_BITS    = `MSP_COMP_BITS,
  parameter int HALF_BIT_CYC = `MSP_HALF_BIT_CYC
) (
  // clock, reset, enable
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  // receiving port, from port logic on sys_clk
  input  wire logic                   rx_active,
  input  wire logic [STATUS_BITS-1:0] status_word,
  // decoded receive stream, from the decoder's own clock
  input  wire logic                   rx_dec_clk,
  input  wire logic                   rx_dec_data,
  // management receive clock pin
  output logic                        mgmt_rx_clock_o,
  output logic                        mgmt_rx_clock_oe,
  // management receive data pin
  output logic                        mgmt_rx_data_o,
  output logic                        mgmt_rx_data_oe,
  // management carrier sense pin
  input  wire logic                   mgmt_carrier_sense_i,
  output logic                        mgmt_carrier_sense_o,
  output logic                        mgmt_carrier_sense_oe,
  // transceiver enable and compress request
  output logic                        mgmt_bus_drive_enable,
  input  wire logic                   packet_compress_n,
  // status towards the rest of the device
  output logic                        mgmt_bus_busy,
  output logic                        compressing,
  // test monitor
  output logic                        rx_manchester_monitor
);

  localparam int CW = $clog2(COMP_BITS + 1);
  localparam int SW = $clog2(STATUS_BITS + 1);
  localparam int DW = $clog2(HALF_BIT_CYC + 1);

  // =====================================================================
  // edge decoding of the synchronised decoder clock, used for data capture, bit counting, sequencing and the pin clock
  function automatic logic rise(input logic now, input logic was);
    rise = now & ~was;
  endfunction : rise

  function automatic logic fall(input logic now, input logic was);
    fall = ~now & was;
  endfunction : fall

  // =====================================================================
  // synchronisers: bit 0 decoded clock, 1 decoded data, 2 carrier sense in,
  // 3 compress request; first stage is read by the second stage only
  logic [3:0] async_in;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic       clk_d_r;

  assign async_in = {packet_compress_n, mgmt_carrier_sense_i, rx_dec_data, rx_dec_clk};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1_r[gi] <= (gi == 3) ? 1'b1 : 1'b0;
          sync2_r[gi] <= (gi == 3) ? 1'b1 : 1'b0;
        end else if (ce) begin
          sync1_r[gi] <= async_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  // previous decoded clock level for edge finding
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_d_r <= 1'b0;
    end else if (ce) begin
      clk_d_r <= sync2_r[0];
    end
  end

  logic dec_rise;
  logic dec_fall;
  assign dec_rise = rise(sync2_r[0], clk_d_r);
  assign dec_fall = fall(sync2_r[0], clk_d_r);

  // =====================================================================
  // state
  msp_state_t              state_r;
  logic                    clk_r;
  logic                    data_r;
  logic                    hold_r;
  logic                    comp_r;
  logic [CW-1:0]           bit_cnt_r;
  logic [SW-1:0]           stat_cnt_r;
  logic [DW-1:0]           div_r;
  logic [STATUS_BITS-1:0]  shift_r;
  logic                    busy_r;
  logic                    driving;
  logic                    div_wrap;

  assign driving  = (state_r != msp_idle);
  assign div_wrap = (div_r == DW'(HALF_BIT_CYC - 1));

  // decoded data is taken on the decoder clock's rising edge, where it is
  // stable, and only moved onto the pin at the following falling edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= 1'b0;
    end else if (ce && dec_rise) begin
      hold_r <= sync2_r[1];
    end
  end

  // frame sequencer: packet, optional skip after compression, status trailer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= msp_idle;
    end else if (ce) begin
      case (state_r)
        msp_idle: begin
          // another device owns carrier sense: do not fight it on the bus
          if (rx_active && !busy_r) begin
            state_r <= msp_pkt;
          end
        end
        msp_pkt: begin
          if (!rx_active) begin
            state_r <= msp_stat;
          end else if (comp_r && dec_fall && bit_cnt_r >= CW'(COMP_BITS)) begin
            state_r <= msp_skip;
          end
        end
        msp_skip: begin
          if (!rx_active) begin
            state_r <= msp_stat;
          end
        end
        msp_stat: begin
          if (div_wrap && clk_r && stat_cnt_r == SW'(STATUS_BITS)) begin
            state_r <= msp_idle;
          end
        end
        default: begin
          state_r <= msp_idle;
        end
      endcase
    end
  end

  // compression request is sampled only while carrier sense is driven;
  // it sticks for the rest of the frame
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      comp_r <= 1'b0;
    end else if (ce) begin
      if (state_r == msp_idle) begin
        comp_r <= 1'b0;
      end else if (state_r == msp_pkt && !sync2_r[3]) begin
        comp_r <= 1'b1;
      end
    end
  end

  // packet bits forwarded, saturating at the compression length
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_r <= '0;
    end else if (ce) begin
      if (state_r == msp_idle) begin
        bit_cnt_r <= '0;
      end else if (state_r == msp_pkt && dec_fall && bit_cnt_r < CW'(COMP_BITS)) begin
        bit_cnt_r <= bit_cnt_r + CW'(1);
      end
    end
  end

  // status trailer timebase: the decoder clock may stop after the packet,
  // so the trailer is clocked from a divider of sys_clk
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= '0;
    end else if (ce) begin
      if (state_r != msp_stat || div_wrap) begin
        div_r <= '0;
      end else begin
        div_r <= div_r + DW'(1);
      end
    end
  end

  // status word is captured as the packet ends and sent lsb first
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r    <= '0;
      stat_cnt_r <= '0;
    end else if (ce) begin
      if (state_r != msp_stat) begin
        shift_r    <= status_word;
        stat_cnt_r <= '0;
      end else if (div_wrap && clk_r && stat_cnt_r != SW'(STATUS_BITS)) begin
        shift_r    <= shift_r >> 1;
        stat_cnt_r <= stat_cnt_r + SW'(1);
      end
    end
  end

  // =====================================================================
  // pin clock and data: both change together at the clock's falling edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_r  <= 1'b0;
      data_r <= 1'b0;
    end else if (ce) begin
      case (state_r)
        msp_pkt: begin
          if (!rx_active) begin
            clk_r <= 1'b1;                                      // trailer starts high
          end else if (dec_rise) begin
            clk_r <= 1'b1;
          end else if (dec_fall) begin
            clk_r  <= 1'b0;
            data_r <= hold_r;
          end
        end
        msp_skip: begin
          // compressed tail: clock parked low so no bit is sampled; data holds,
          // since a move here would change the line without a clock fall
          clk_r <= rx_active ? 1'b0 : 1'b1;
        end
        msp_stat: begin
          if (div_wrap) begin
            clk_r <= ~clk_r;
            if (clk_r) begin
              data_r <= (stat_cnt_r == SW'(STATUS_BITS)) ? 1'b0 : shift_r[0];
            end
          end
        end
        default: begin
          clk_r  <= 1'b0;
          data_r <= 1'b0;
        end
      endcase
    end
  end

  // carrier sense seen from others, only meaningful while we do not drive
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
    end else if (ce) begin
      busy_r <= ~driving & sync2_r[2];
    end
  end

  // =====================================================================
  // pin drivers
  assign mgmt_rx_clock_o       = clk_r;
  assign mgmt_rx_clock_oe      = driving;
  assign mgmt_rx_data_o        = data_r;
  assign mgmt_rx_data_oe       = driving;
  assign mgmt_carrier_sense_o  = driving;
  assign mgmt_carrier_sense_oe = driving;
  assign mgmt_bus_drive_enable = driving;
  assign mgmt_bus_busy         = busy_r;
  assign compressing           = comp_r;

  // test monitor of the receiving port's data
  msp_manchester_mon u_mon (
    .sys_clk               (sys_clk),
    .rst_n                 (rst_n),
    .ce                    (ce),
    .rx_active             (rx_active),
    .nrz_clk               (sync2_r[0]),
    .nrz_data              (sync2_r[1]),
    .rx_manchester_monitor (rx_manchester_monitor)
  );

endmodule : msp_packet_output

`default_nettype wire

// ### verification/msp_packet_output_props.sv
// checker of the management serial packet output
`timescale 1ns/10ps
`default_nettype none

module msp_packet_output_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  // watched ports
  input wire logic rx_active,
  input wire logic mgmt_rx_clock_o,
  input wire logic mgmt_rx_clock_oe,
  input wire logic mgmt_rx_data_o,
  input wire logic mgmt_rx_data_oe,
  input wire logic mgmt_carrier_sense_o,
  input wire logic mgmt_carrier_sense_oe,
  input wire logic mgmt_bus_drive_enable,
  input wire logic mgmt_bus_busy,
  input wire logic compressing,
  input wire logic rx_manchester_monitor
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ===================================================================
  // framing and drive
  a_frame_start: assert property (ce && rx_active && !mgmt_bus_busy && !mgmt_carrier_sense_oe
    |=> mgmt_carrier_sense_oe) else $error("frame did not start");
  a_busy_defer: assert property (mgmt_bus_busy && !mgmt_carrier_sense_oe
    |=> !mgmt_carrier_sense_oe) else $error("frame started on a busy bus");
  a_cs_level: assert property (mgmt_carrier_sense_oe |-> mgmt_carrier_sense_o)
    else $error("carrier sense low while driven");
  a_enable_all: assert property (mgmt_bus_drive_enable |-> mgmt_rx_clock_oe && mgmt_rx_data_oe
    && mgmt_carrier_sense_oe) else $error("drive enable without drivers");
  a_enable_only: assert property (mgmt_rx_clock_oe || mgmt_rx_data_oe |-> mgmt_bus_drive_enable)
    else $error("pin driven without drive enable");
  a_idle_quiet: assert property (!mgmt_rx_clock_oe |-> !mgmt_rx_clock_o && !mgmt_rx_data_o)
    else $error("clock or data active while released");

  // ===================================================================
  // stream timing
  a_data_on_fall: assert property (mgmt_rx_data_oe && $past(mgmt_rx_data_oe)
    && $changed(mgmt_rx_data_o) |-> $fell(mgmt_rx_clock_o)) else $error("data moved off the fall");
  a_trailer_clock: assert property ($fell(rx_active) && mgmt_rx_clock_oe
    |=> mgmt_rx_clock_o [*6] ##1 !mgmt_rx_clock_o) else $error("status clock off");
  a_compress_hold: assert property (compressing && mgmt_carrier_sense_oe |=> compressing || !mgmt_carrier_sense_oe)
    else $error("compression dropped mid frame");
  a_monitor_gate: assert property (rx_manchester_monitor |-> $past(rx_active))
    else $error("monitor active without a receiving port");
endmodule : msp_packet_output_props

bind msp_packet_output msp_packet_output_props u_props (.sys_clk, .rst_n, .ce, .rx_active,
  .mgmt_rx_clock_o, .mgmt_rx_clock_oe, .mgmt_rx_data_o, .mgmt_rx_data_oe, .mgmt_carrier_sense_o,
  .mgmt_carrier_sense_oe, .mgmt_bus_drive_enable, .mgmt_bus_busy, .compressing, .rx_manchester_monitor);

`default_nettype wire

// ### verification/msp_mgmt_collector.sv
// far-end collector model on the management bus
`timescale 1ns/10ps
`default_nettype none

module msp_mgmt_collector (
  // device pin drivers
  input  wire logic        clk_o,
  input  wire logic        clk_oe,
  input  wire logic        data_o,
  input  wire logic        data_oe,
  input  wire logic        cs_o,
  input  wire logic        cs_oe,
  // bench controls
  input  wire logic        hold_bus,
  input  wire logic        want_comp,
  // resolved line and results
  output logic             cs_line,
  output logic             packet_compress_n,
  output logic [15:0]      bit_cnt,
  output logic [15:0]      last_bits
);
  logic clk_line;

  // board pull-downs: a released clock line reads low, never the last value; a released carrier sense line reads hold_bus
  assign clk_line = clk_oe & clk_o;
  assign cs_line = cs_oe ? cs_o : hold_bus;
  // request held low across the whole carrier frame
  assign packet_compress_n = ~want_comp;

  initial begin
    bit_cnt = 16'h0000;
    last_bits = 16'h0000;
  end

  // sample on the rise, so data must have settled at the fall before
  always @(posedge clk_line) begin
    if (cs_line) begin
      bit_cnt <= bit_cnt + 16'h0001;
      last_bits <= {data_oe & data_o, last_bits[15:1]};
    end
  end
endmodule : msp_mgmt_collector

`default_nettype wire

// ### verification/tb_top.sv
// testbench of the management serial packet output
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  localparam int CB = 8;
  logic sys_clk = 0, rst_n = 0, rx_active = 0, dck = 0, dd = 0, hold = 0, want = 0;
  logic [7:0] status = 8'h00;
  logic clk_o, clk_oe, d_o, d_oe, cs_o, cs_oe, cs_line, pcn, drv_en, busy, comp, mon;
  logic [15:0] cnt, bits, base;
  int n_mismatch = 0, n_compared = 0, mon_hits = 0, comp_hits = 0;

  always #4 sys_clk = ~sys_clk;
  // count monitor and compression activity seen at the pins
  always @(posedge sys_clk) begin
    if (mon === 1'b1) mon_hits++;
    if (comp === 1'b1) comp_hits++;
  end

  msp_packet_output #(.COMP_BITS(CB)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1),
    .rx_active(rx_active), .status_word(status), .rx_dec_clk(dck), .rx_dec_data(dd),
    .mgmt_rx_clock_o(clk_o), .mgmt_rx_clock_oe(clk_oe), .mgmt_rx_data_o(d_o), .mgmt_rx_data_oe(d_oe),
    .mgmt_carrier_sense_i(cs_line), .mgmt_carrier_sense_o(cs_o), .mgmt_carrier_sense_oe(cs_oe),
    .mgmt_bus_drive_enable(drv_en), .packet_compress_n(pcn), .mgmt_bus_busy(busy),
    .compressing(comp), .rx_manchester_monitor(mon));

  msp_mgmt_collector peer (.clk_o(clk_o), .clk_oe(clk_oe), .data_o(d_o), .data_oe(d_oe),
    .cs_o(cs_o), .cs_oe(cs_oe), .hold_bus(hold), .want_comp(want), .cs_line(cs_line),
    .packet_compress_n(pcn), .bit_cnt(cnt), .last_bits(bits));

  task automatic report_and_stop;
    if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (exp !== got) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // inputs set after tick land one ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // decoder clock runs only inside the frame, out of phase with sys_clk
  task automatic frame(input logic [7:0] st, input int nb, input logic [31:0] pat);
    base = cnt;
    status = st;
    rx_active = 1;
    tick(2);
    #3;
    for (int i = 0; i < nb; i++) begin
      dd = pat[i];
      #32 dck = 1;
      #32 dck = 0;
    end
    tick(6);
    rx_active = 0;
    for (int i = 0; i < 400 && cs_oe !== 1'b0; i++) tick(1);
    if (cs_oe !== 1'b0) begin
      n_mismatch++;
      report_and_stop;
    end
  endtask : frame

  task automatic sc_plain;
    frame(8'hA5, 20, 32'h000B_36C9);
    check("tail and status", {8'hA5, 8'hB3}, bits);
    check("bits seen", 16'h0001, 16'(cnt - base >= 16'd28));
    check("monitor active", 16'h0001, 16'(mon_hits > 0));
    check("released lines", 16'h0000, {drv_en, cs_line, mon});
  endtask : sc_plain

  task automatic sc_compress;
    want = 1;
    frame(8'h3C, 20, 32'h000F_FFFF);
    want = 0;
    check("compressed", 16'h0001, 16'(comp_hits > 0));
    check("truncated", 16'h0001, 16'(cnt - base <= 16'(CB + 10)));
    check("status kept", 16'h003C, 16'(bits[15:8]));
  endtask : sc_compress

  task automatic sc_busy;
    base = cnt;
    hold = 1;
    tick(4);
    rx_active = 1;
    tick(30);
    check("busy seen", 16'h0001, 16'(busy));
    check("deferred", 16'h0000, {13'h0000, cs_oe, drv_en, clk_oe});
    check("no bits while deferred", 16'h0000, cnt - base);
    rx_active = 0;
    hold = 0;
    tick(4);
  endtask : sc_busy

  task automatic sc_reset;
    rx_active = 1;
    tick(8);
    rst_n = 0;
    rx_active = 0;
    #1;
    check("reset drop", 16'h0000, {drv_en, cs_oe, clk_oe, d_oe, mon, comp});
    tick(20);
    rst_n = 1;
    tick(3);
  endtask : sc_reset

  initial begin
    tick(20);
    rst_n = 1;
    tick(3);
    sc_plain;
    sc_compress;
    sc_busy;
    sc_reset;
    sc_plain;
    report_and_stop;
  end
endmodule : tb_top

`default_nettype wire
